// file: hw/pdc_port_device_capabilities.sv
`timescale 1ns/1ps
`default_nettype none
module pdc_port_device_capabilities
	import pdc_pkg::*;
#(
	parameter int ADDR_W = PDC_ADDR_W  // apb address width
)
(
	input  wire logic                  pclk,              // core clock, 100 MHz
	input  wire logic                  presetn,           // async reset, active low
	input  wire logic [ADDR_W-1:0]     paddr,             // apb byte address
	input  wire logic                  psel,              // apb select
	input  wire logic                  penable,           // apb access phase
	input  wire logic                  pwrite,            // apb direction, 1 = write
	input  wire logic [PDC_DATA_W-1:0] pwdata,            // apb write data
	input  wire logic [PDC_STRB_W-1:0] pstrb,             // apb byte strobes
	output logic      [PDC_DATA_W-1:0] prdata,            // apb read data
	output logic                       pready,            // apb ready
	output logic                       pslverr,           // apb error, unmapped address
	input  wire logic                  port_is_upstream,  // 1 on the upstream port
	input  wire logic                  spl_msg_valid,     // one cycle: slot power message received
	input  wire logic [PDC_CPLV_W-1:0] spl_msg_value,     // limit value from the message
	input  wire logic [PDC_CPLS_W-1:0] spl_msg_scale,     // limit scale from the message
	output logic      [PDC_CPLV_W-1:0] power_limit_value, // captured value for the port logic
	output logic      [PDC_CPLS_W-1:0] power_limit_scale  // captured scale for the port logic
);

	// the decode compares twelve bits, so narrower buses cannot reach the map
	if (ADDR_W < PDC_ADDR_W)
	begin : g_addr_check
		$error("ADDR_W must be at least 12");
	end

	// slave handshake states
	typedef enum logic {
		PDC_ST_IDLE,
		PDC_ST_DONE
	} pdc_state_t;

	pdc_state_t                state_ff;        // handshake state
	pdc_state_t                nxt_state;
	logic                      pready_ff;       // ready towards the master
	logic                      nxt_pready;
	logic                      pslverr_ff;      // error towards the master
	logic                      nxt_pslverr;
	logic [PDC_DATA_W-1:0]     prdata_ff;       // read data towards the master
	logic [PDC_DATA_W-1:0]     nxt_prdata;
	logic [PDC_MPS_W-1:0]      mps_ff;          // max_payload_supported
	logic [PDC_MPS_W-1:0]      nxt_mps;
	logic                      extended_tag_support_ff;         // extended_tag_support
	logic                      nxt_extended_tag_support;
	logic                      unlock_ff;       // lockable_read_write gate
	logic                      nxt_unlock;
	logic [PDC_CPLV_W-1:0]     cap_value;       // captured power value, from a flop
	logic [PDC_CPLS_W-1:0]     cap_scale;       // captured power scale, from a flop
	pdc_sel_t                  sel;             // register addressed this cycle
	logic                      commit;          // write completes at this edge

	// maps a byte address onto the register it selects
	function automatic pdc_sel_t pdc_decode(input logic [ADDR_W-1:0] addr);
		logic [PDC_ADDR_W-1:0] low;
		low = addr[PDC_ADDR_W-1:0];
		if (addr != ADDR_W'(low))
			pdc_decode = PDC_SEL_NONE;  // upper bits set, outside the map
		else if (low == PDC_CAP_OFFSET)
			pdc_decode = PDC_SEL_CAP;
		else if (low == PDC_LOCK_OFFSET)
			pdc_decode = PDC_SEL_LOCK;
		else
			pdc_decode = PDC_SEL_NONE;
	endfunction

	// builds the capabilities word from its live and constant fields
	function automatic logic [PDC_DATA_W-1:0] pdc_cap_word(
		input logic [PDC_MPS_W-1:0]  mps,
		input logic                  extended_tag_support,
		input logic [PDC_CPLV_W-1:0] value,
		input logic [PDC_CPLS_W-1:0] scale
	);
		logic [PDC_DATA_W-1:0] w;
		w                                       = PDC_ZERO_WORD;  // reserved 17:16, 31:28 stay zero
		w[PDC_MPS_LSB +: PDC_MPS_W]             = mps;
		w[PDC_PFS_LSB +: 2]                     = PDC_PFS_VAL;
		w[PDC_EXTENDED_TAG_SUPPORT_BIT]                         = extended_tag_support;
		w[PDC_STBY_LSB +: 3]                    = PDC_LAT_VAL;
		w[PDC_SLEEP_LSB +: 3]                   = PDC_LAT_VAL;
		w[PDC_ABP_BIT]                          = PDC_IND_VAL;
		w[PDC_AIP_BIT]                          = PDC_IND_VAL;
		w[PDC_PIP_BIT]                          = PDC_IND_VAL;
		w[PDC_ROLE_BASED_ERR_REPORTING_BIT]                        = PDC_ROLE_BASED_ERR_REPORTING_VAL;
		// software scales value by 1.0, 0.1, 0.01 or 0.001 per scale code
		w[PDC_CPLV_LSB +: PDC_CPLV_W]           = value;
		w[PDC_CPLS_LSB +: PDC_CPLS_W]           = scale;
		pdc_cap_word = w;
	endfunction

	// captured slot power limit lives in its own unit
	pdc_power_capture u_capture (
		.pclk             (pclk),
		.presetn          (presetn),
		.port_is_upstream (port_is_upstream),
		.spl_msg_valid    (spl_msg_valid),
		.spl_msg_value    (spl_msg_value),
		.spl_msg_scale    (spl_msg_scale),
		.value_ff         (cap_value),
		.scale_ff         (cap_scale)
	);

	// decode is shared by the read path and the write commit
	assign sel    = pdc_decode(paddr);
	// a write lands only on the edge at which the master sees pready high
	assign commit = (state_ff == PDC_ST_DONE) && psel && penable && pwrite;

	// apb handshake: one wait state, answer data prepared one edge early
	always_comb
	begin
		nxt_state   = state_ff;
		nxt_pready  = 1'b0;
		nxt_pslverr = 1'b0;
		nxt_prdata  = PDC_ZERO_WORD;
		case (state_ff)
			PDC_ST_IDLE:
			begin
				// access phase seen: prepare the answer for the next edge
				if (psel && penable)
				begin
					nxt_state   = PDC_ST_DONE;
					nxt_pready  = 1'b1;
					nxt_pslverr = (sel == PDC_SEL_NONE);
					if (!pwrite)
					begin
						case (sel)
							PDC_SEL_CAP:
								nxt_prdata = pdc_cap_word(mps_ff, extended_tag_support_ff, cap_value, cap_scale);
							PDC_SEL_LOCK:
							begin
								nxt_prdata                 = PDC_ZERO_WORD;
								nxt_prdata[PDC_UNLOCK_BIT] = unlock_ff;
							end
							default:
								nxt_prdata = PDC_ZERO_WORD;  // unmapped reads return zero
						endcase
					end
				end
			end
			PDC_ST_DONE:
			begin
				// transfer completes here; pready drops so the next one waits again
				nxt_state = PDC_ST_IDLE;
			end
			default:
			begin
				nxt_state = PDC_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_ff   <= PDC_ST_IDLE;
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= PDC_ZERO_WORD;
		end
		else
		begin
			state_ff   <= nxt_state;
			pready_ff  <= nxt_pready;
			pslverr_ff <= nxt_pslverr;
			prdata_ff  <= nxt_prdata;
		end
	end

	// lockable fields and the unlock gate
	always_comb
	begin
		nxt_mps    = mps_ff;
		nxt_extended_tag_support   = extended_tag_support_ff;
		nxt_unlock = unlock_ff;
		if (commit && pstrb[0])
		begin
			if (sel == PDC_SEL_LOCK)
			begin
				nxt_unlock = pwdata[PDC_UNLOCK_BIT];
			end
			else if ((sel == PDC_SEL_CAP) && unlock_ff)
			begin
				// only the unlocked initialisation path reaches these fields
				nxt_mps  = pwdata[PDC_MPS_LSB +: PDC_MPS_W];
				nxt_extended_tag_support = pwdata[PDC_EXTENDED_TAG_SUPPORT_BIT];
			end
			// all other bits of the word are constants or captured: writes drop
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mps_ff    <= PDC_MPS_RST;
			extended_tag_support_ff   <= PDC_EXTENDED_TAG_SUPPORT_RST;
			unlock_ff <= PDC_UNLOCK_RST;
		end
		else
		begin
			mps_ff    <= nxt_mps;
			extended_tag_support_ff   <= nxt_extended_tag_support;
			unlock_ff <= nxt_unlock;
		end
	end

	// outputs straight from flops
	assign prdata            = prdata_ff;
	assign pready            = pready_ff;
	assign pslverr           = pslverr_ff;
	assign power_limit_value = cap_value;
	assign power_limit_scale = cap_scale;

endmodule
`default_nettype wire

// file: hw/pdc_pkg.sv
// shared constants for the port device capabilities register bank
package pdc_pkg;

	// apb geometry
	localparam int          PDC_ADDR_W        = 12;             // byte address width seen by the slave
	localparam int          PDC_DATA_W        = 32;             // apb data width
	localparam int          PDC_STRB_W        = 4;              // byte lanes

	// register map, byte addresses
	localparam logic [11:0] PDC_CAP_OFFSET    = 12'h044;        // capabilities word
	localparam logic [11:0] PDC_LOCK_OFFSET   = 12'h0f0;        // unlock control for lockable fields

	// field positions in the capabilities word
	localparam int          PDC_MPS_LSB       = 0;              // max_payload_supported 2:0
	localparam int          PDC_MPS_W         = 3;
	localparam int          PDC_PFS_LSB       = 3;              // phantom_func_support 4:3
	localparam int          PDC_EXTENDED_TAG_SUPPORT_BIT      = 5;              // extended_tag_support
	localparam int          PDC_STBY_LSB      = 6;              // standby_accept_latency 8:6
	localparam int          PDC_SLEEP_LSB     = 9;              // sleep_accept_latency 11:9
	localparam int          PDC_ABP_BIT       = 12;             // attn_button_present
	localparam int          PDC_AIP_BIT       = 13;             // attn_indicator_present
	localparam int          PDC_PIP_BIT       = 14;             // pwr_indicator_present
	localparam int          PDC_ROLE_BASED_ERR_REPORTING_BIT     = 15;             // role_based_err_reporting
	localparam int          PDC_CPLV_LSB      = 18;             // captured_power_limit_value 25:18
	localparam int          PDC_CPLV_W        = 8;
	localparam int          PDC_CPLS_LSB      = 26;             // captured_power_limit_scale 27:26
	localparam int          PDC_CPLS_W        = 2;

	// field position in the lock control word
	localparam int          PDC_UNLOCK_BIT    = 0;              // 1 lets writes reach lockable fields

	// reset and constant values
	localparam logic [2:0]  PDC_MPS_RST       = 3'h4;           // 2048 byte payloads
	localparam logic        PDC_EXTENDED_TAG_SUPPORT_RST      = 1'h1;           // larger tag field supported
	localparam logic [1:0]  PDC_PFS_VAL       = 2'h0;           // no phantom functions
	localparam logic [2:0]  PDC_LAT_VAL       = 3'h0;           // latencies do not apply
	localparam logic        PDC_IND_VAL       = 1'h0;           // no button or indicators
	localparam logic        PDC_ROLE_BASED_ERR_REPORTING_VAL     = 1'h1;           // role based error reporting
	localparam logic        PDC_UNLOCK_RST    = 1'h0;           // locked after reset
	localparam logic [7:0]  PDC_CPLV_RST      = 8'h00;
	localparam logic [1:0]  PDC_CPLS_RST      = 2'h0;
	localparam logic [31:0] PDC_ZERO_WORD     = 32'h0000_0000;

	// register selected by an address
	typedef enum logic [1:0] {
		PDC_SEL_NONE,
		PDC_SEL_CAP,
		PDC_SEL_LOCK
	} pdc_sel_t;

endpackage

// file: hw/pdc_power_capture.sv
`timescale 1ns/1ps
`default_nettype none
// holds the slot power limit taken from the last message on an upstream port
module pdc_power_capture
	import pdc_pkg::*;
(
	input  wire logic                  pclk,              // core clock
	input  wire logic                  presetn,           // async reset, active low
	input  wire logic                  port_is_upstream,  // 1 on the upstream port
	input  wire logic                  spl_msg_valid,     // one cycle: slot power message received
	input  wire logic [PDC_CPLV_W-1:0] spl_msg_value,     // limit value carried by the message
	input  wire logic [PDC_CPLS_W-1:0] spl_msg_scale,     // limit scale carried by the message
	output logic      [PDC_CPLV_W-1:0] value_ff,          // captured value
	output logic      [PDC_CPLS_W-1:0] scale_ff           // captured scale
);

	logic [PDC_CPLV_W-1:0] nxt_value;  // next captured value
	logic [PDC_CPLS_W-1:0] nxt_scale;  // next captured scale

	// load on a message, forced to zero whenever the port faces downstream
	always_comb
	begin
		nxt_value = value_ff;
		nxt_scale = scale_ff;
		if (!port_is_upstream)
		begin
			// downstream ports ignore messages and read zero from the next edge on
			nxt_value = PDC_CPLV_RST;
			nxt_scale = PDC_CPLS_RST;
		end
		else if (spl_msg_valid)
		begin
			// value and scale always come from the same message, so they never mix
			nxt_value = spl_msg_value;
			nxt_scale = spl_msg_scale;
		end
	end

	// register the captured limit
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			value_ff <= PDC_CPLV_RST;
			scale_ff <= PDC_CPLS_RST;
		end
		else
		begin
			value_ff <= nxt_value;
			scale_ff <= nxt_scale;
		end
	end

endmodule
`default_nettype wire

// file: testbench/pdc_spl_partner.sv
`timescale 1ns/1ps
`default_nettype none
// upstream link partner: hands over one slot power message at a time
module pdc_spl_partner
	import pdc_pkg::*;
(
	input  wire logic                  pclk,          // core clock
	output logic                       spl_msg_valid, // one cycle pulse
	output logic      [PDC_CPLV_W-1:0] spl_msg_value, // limit value
	output logic      [PDC_CPLS_W-1:0] spl_msg_scale  // limit scale
);
	initial
	begin
		spl_msg_valid = 1'h0;
		spl_msg_value = 8'h00;
		spl_msg_scale = 2'h0;
	end
	// value and scale travel together; lines are scrambled once the pulse ends
	task send(input logic [7:0] v, input logic [1:0] s);
		@(posedge pclk);
		spl_msg_valid <= 1'h1;
		spl_msg_value <= v;
		spl_msg_scale <= s;
		@(posedge pclk);
		spl_msg_valid <= 1'h0;
		spl_msg_value <= ~v;
		spl_msg_scale <= ~s;
	endtask
endmodule
`default_nettype wire

// file: testbench/pdc_chk.sv
`timescale 1ns/1ps
`default_nettype none
// apb timing, constant fields and power capture seen at the top ports
module pdc_chk
	import pdc_pkg::*;
#(
	parameter int ADDR_W = PDC_ADDR_W
)
(
	input wire logic              pclk,
	input wire logic              presetn,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [31:0]       prdata,
	input wire logic              pready,
	input wire logic              pslverr,
	input wire logic              port_is_upstream,
	input wire logic              spl_msg_valid,
	input wire logic [7:0]        spl_msg_value,
	input wire logic [1:0]        spl_msg_scale,
	input wire logic [7:0]        power_limit_value,
	input wire logic [1:0]        power_limit_scale
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic rd_cap; // answered read of the capabilities word
	logic mapped; // address hits one of the two registers
	assign rd_cap = pready && !pwrite && !pslverr && paddr == ADDR_W'(PDC_CAP_OFFSET);
	assign mapped = paddr == ADDR_W'(PDC_CAP_OFFSET) || paddr == ADDR_W'(PDC_LOCK_OFFSET);
	a_one_wait: assert property (psel && $rose(penable) |=> pready) else $error("no answer after one wait");
	a_ready_pulse: assert property (pready |=> !pready) else $error("pready held too long");
	a_rdata_idle: assert property (!pready |-> prdata == 32'h0) else $error("read data outside answer");
	a_err_decode: assert property (pready |-> pslverr == !mapped) else $error("error flag wrong for address");
	a_const_fields: assert property (rd_cap |-> prdata[31:28] == 4'h0 && prdata[4:3] == 2'h0
		&& prdata[17:6] == 12'h200) else $error("fixed field wrong");
	// read data was built one edge before the answer, so it mirrors the outputs of that edge
	a_field_mirror: assert property (rd_cap |-> prdata[25:18] == $past(power_limit_value)
		&& prdata[27:26] == $past(power_limit_scale)) else $error("captured fields differ from outputs");
	a_msg_capture: assert property (spl_msg_valid && port_is_upstream |=>
		power_limit_value == $past(spl_msg_value) && power_limit_scale == $past(spl_msg_scale))
		else $error("message not captured");
	a_down_zero: assert property (!port_is_upstream |=> power_limit_value == 8'h0 && power_limit_scale == 2'h0)
		else $error("downstream power not zero");
	a_hold_power: assert property (port_is_upstream && !spl_msg_valid |=> $stable(power_limit_value)
		&& $stable(power_limit_scale)) else $error("captured power changed alone");
	c_read_cap: cover property (rd_cap);
	c_capture: cover property (spl_msg_valid && port_is_upstream);
	c_unmapped: cover property (pready && pslverr);
endmodule
bind pdc_port_device_capabilities pdc_chk #(.ADDR_W(ADDR_W)) u_chk (.pclk(pclk), .presetn(presetn),
	.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .port_is_upstream(port_is_upstream), .spl_msg_valid(spl_msg_valid),
	.spl_msg_value(spl_msg_value), .spl_msg_scale(spl_msg_scale), .power_limit_value(power_limit_value),
	.power_limit_scale(power_limit_scale));
`default_nettype wire

// file: testbench/tb_port_device_capabilities.sv
`timescale 1ns/1ps
`default_nettype none
module tb_port_device_capabilities;
	import pdc_pkg::*;
	logic        pclk = 1'h0;   // 100 MHz
	logic        presetn = 1'h0;
	logic [11:0] paddr = 12'h0;
	logic        psel = 1'h0;
	logic        penable = 1'h0;
	logic        pwrite = 1'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        up = 1'h1;     // port role
	logic        mv;
	logic [7:0]  mval;
	logic [1:0]  msc;
	logic [7:0]  plv;
	logic [1:0]  pls;
	logic [31:0] rd;            // data taken at the answer
	logic        er;            // error taken at the answer
	int          n_mismatch = 0;
	int          compares = 0;
	int          cyc = 0;
	always #5 pclk = ~pclk;
	pdc_port_device_capabilities DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .port_is_upstream(up), .spl_msg_valid(mv), .spl_msg_value(mval),
		.spl_msg_scale(msc), .power_limit_value(plv), .power_limit_scale(pls));
	pdc_spl_partner pm (.pclk(pclk), .spl_msg_valid(mv), .spl_msg_value(mval), .spl_msg_scale(msc));
	task conclude;
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task ck(input string nm, input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// one apb transfer; request held until the rising edge that samples pready high
	// answer is taken at that edge, before the slave's own update of it
	task ap(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	// hang guard
	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 4000)
		begin
			n_mismatch++;
			conclude;
		end
	end
	initial
	begin
		repeat (8) @(posedge pclk);
		presetn <= 1'h1;
		ap(1'h0, PDC_CAP_OFFSET, 32'h0); ck("cap reset", rd, 32'h0000_8024);
		ap(1'h1, PDC_CAP_OFFSET, 32'hffff_ffff);
		ap(1'h0, PDC_CAP_OFFSET, 32'h0); ck("cap locked", rd, 32'h0000_8024);
		ap(1'h0, 12'h048, 32'h0); ck("unmapped", {rd[30:0], er}, 32'h1);
		ap(1'h1, PDC_LOCK_OFFSET, 32'h1);
		ap(1'h0, PDC_LOCK_OFFSET, 32'h0); ck("lock back", rd, 32'h1);
		ap(1'h1, PDC_CAP_OFFSET, 32'hffff_ffff);
		ap(1'h0, PDC_CAP_OFFSET, 32'h0); ck("cap unlocked", rd, 32'h0000_8027);
		ap(1'h1, PDC_CAP_OFFSET, 32'h0);
		ap(1'h1, PDC_LOCK_OFFSET, 32'h0);
		ap(1'h1, PDC_CAP_OFFSET, 32'hffff_ffff);
		ap(1'h0, PDC_CAP_OFFSET, 32'h0); ck("cap relocked", rd, 32'h0000_8000);
		for (int s = 0; s < 4; s++)
		begin
			pm.send(8'h5a + 8'(s), 2'(s));
			ap(1'h0, PDC_CAP_OFFSET, 32'h0);
			ck("cap power", rd, {4'h0, 2'(s), 8'h5a + 8'(s), 18'h08000});
			ck("power out", {22'h0, pls, plv}, {22'h0, 2'(s), 8'h5a + 8'(s)});
		end
		up <= 1'h0;
		pm.send(8'hc3, 2'h2);
		ap(1'h0, PDC_CAP_OFFSET, 32'h0); ck("cap down", rd, 32'h0000_8000);
		ck("power down", {22'h0, pls, plv}, 32'h0);
		// second reset in mid-run: lockable fields, unlock gate and captured power restart
		ap(1'h1, PDC_LOCK_OFFSET, 32'h1);
		ap(1'h1, PDC_CAP_OFFSET, 32'h0);
		up <= 1'h1;
		pm.send(8'h77, 2'h1);
		@(posedge pclk);
		presetn <= 1'h0;
		repeat (2) @(posedge pclk);
		presetn <= 1'h1;
		ap(1'h1, PDC_CAP_OFFSET, 32'h0);
		ap(1'h0, PDC_CAP_OFFSET, 32'h0); ck("cap after reset", rd, 32'h0000_8024);
		ck("power after reset", {22'h0, pls, plv}, 32'h0);
		conclude;
	end
endmodule
`default_nettype wire
